//--- verilog/ust_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the UART
 status and test register block. Included by the prescaler and top modules.
*/
`ifndef UST_DEFS_SVH
`define UST_DEFS_SVH
`define UST_OFS_DATA      3'h0
`define UST_OFS_DIV_HIGH  3'h1
`define UST_OFS_ENH_FEAT  3'h2
`define UST_OFS_LINE_CTL  3'h3
`define UST_OFS_MODEM_CTL 3'h4
`define UST_OFS_LINE_STAT 3'h5
`define UST_OFS_MODEM_STA 3'h6
`define UST_LS_RESET      8'h60
`define UST_MS_RESET      8'h00
`define UST_FT_RESET      8'h00
`define UST_MC_RESET      8'h00
`define UST_LC_RESET      8'h00
`define UST_LC_ENH_ACCESS 8'hBF
`define UST_LC_DIV_BIT    7
`define UST_EF_ENH_BIT    4
`define UST_MC_LOOP_BIT   4
`define UST_MC_PRESC_BIT  7
`define UST_MC_EXT_MASK   8'hE0
`define UST_FT_USED_MASK  8'h1F
`define UST_PRESC_DIV     4
`endif

//--- verilog/ust_pkg.sv
/*
 Types of the UART status and test block. Assumes ust_defs.svh on the
 include path.
*/
package ust_pkg;
  typedef struct packed {
    logic [2:0] address;
    logic       read;
    logic       write;
    logic [7:0] writedata;
  } ust_req_t;
  typedef struct packed {
    logic       cts;
    logic       dsr;
    logic       ri;
    logic       cd;
  } ust_modem_t;
  typedef struct packed {
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       rx_parity_err;
    logic       rx_frame_err;
    logic       rx_break;
  } ust_rx_t;
  typedef enum logic [1:0] {
    UST_IDLE = 2'b01,
    UST_ACK  = 2'b10
  } ust_bus_state_t;
endpackage : ust_pkg

//--- verilog/ust_sync.sv
/*
 Two-flop synchroniser for the modem input pins.
 Assumes pins are asynchronous to clock.
*/
`timescale 1ns/1ps
module ust_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  // Data
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      meta_reg <= '1;
      q        <= '1;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : ust_sync

//--- verilog/ust_prescaler.sv
/*
 Baud generator clock enable: every clock or one in DIV clocks.
 Assumes a single clock domain.
*/
`timescale 1ns/1ps
`include "ust_defs.svh"
module ust_prescaler #(
  parameter int DIV = `UST_PRESC_DIV
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Control
  input  wire logic divide,
  output      logic tick
);
  logic [$clog2(DIV)-1:0] cnt_reg;
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      cnt_reg <= '0;
    else
      cnt_reg <= (cnt_reg == ($clog2(DIV))'(DIV - 1)) ? '0 : cnt_reg + 1'b1;
  end
  assign tick = divide ? (cnt_reg == '0) : 1'b1;
endmodule : ust_prescaler

//--- verilog/ust_top.sv
/*
 Status and test registers of one UART channel: line status, factory test,
 modem status, modem control, line control and enhanced enable, plus the
 baud generator with pre-scaler. Assumes Avalon-MM master on the same
 clock; receive storage, transmitter and shifters sit outside and report
 through the rx and tx status ports.
*/
`timescale 1ns/1ps
`include "ust_defs.svh"
// Operation
// - Modem control bit 7 with enhanced enable selects divide-by-4 baud clock.
// - Line status at offset 5, resets 0x60, hidden under enhanced access value.
// - Bit 0 shows received data waiting; clears once storage empties.
// - Overrun keeps stored data, sets bit 1, cleared by line status read.
// - Bit 2 shows parity error of head byte, cleared on data read.
// - Bit 3 shows framing error of head byte, cleared on data read.
// - Long low input stores one break byte, flags bit 4 until data read.
// - Bit 5 high while transmit storage has a free location.
// - Bit 6 high only when transmit storage and shifter both empty.
// - Bit 7 set while any stored receive byte carries an error.
// - Test bit 0 routes offset 0 to transmit FIFO, no transmission.
// - Test bit 1 routes offset 0 accesses straight to receive FIFO.
// - Test bit 2 makes transmitter send wrong parity.
// - Test bit 3 makes transmitter send stop bit as zero.
// - Test bit 4 makes divisor reads return live baud counter.
// - Modem status at offset 6, resets to 0x00.
// - Delta CTS, DSR, CD latch changes, clear on read, request interrupt.
// - Delta RI latches only falling RI (trailing edge of ring), clears on read.
// - Bits 4 to 7 show inverted CTS, DSR, RI, CD inputs.
// - In loopback bits 4 to 7 mirror RTS, DTR, output one, output two.
// - Enhanced enable gates extended modem control bits.
// - Modem control bit 4 selects internal loopback.
// - Line control bit 7 maps divisor latches on low offsets.
module ust_top (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_b,
  // Avalon-MM slave
  input  wire logic [2:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [7:0]          writedata,
  output      logic [7:0]          readdata,
  output      logic                waitrequest,
  // Modem pins, active low; modem interrupt request active high
  input  wire ust_pkg::ust_modem_t modem_in_b,
  output      logic                dtr_b,
  output      logic                rts_b,
  output      logic                modem_irq,
  // Receive storage status and head byte
  input  wire ust_pkg::ust_rx_t    rx_head,
  input  wire logic                rx_full,
  input  wire logic                rx_any_err,
  input  wire logic                rx_byte_arrived,
  output      logic                rx_pop,
  output      logic                rx_test_push,
  // Transmit storage status
  input  wire logic                tx_full,
  input  wire logic                tx_empty,
  input  wire logic                tx_shift_busy,
  input  wire logic [7:0]          tx_test_data,
  output      logic                tx_push,
  output      logic [7:0]          tx_data,
  output      logic                tx_test_pop,
  output      logic                tx_inhibit,
  output      logic                tx_bad_parity,
  output      logic                tx_bad_stop,
  // Baud generator
  output      logic                baud_tick,
  output      logic                loopback
);
  import ust_pkg::*;

  ust_bus_state_t state_reg;
  ust_req_t       req;
  ust_modem_t     modem_s_b;
  logic [7:0]     line_ctl_reg;
  logic [7:0]     enh_feat_reg;
  logic [7:0]     modem_ctl_reg;
  logic [7:0]     factory_test_reg;
  logic [7:0]     div_low_reg;
  logic [7:0]     div_high_reg;
  logic [15:0]    baud_cnt_reg;
  logic [3:0]     delta_reg;
  logic [3:0]     status_now;
  logic [3:0]     status_prev_reg;
  logic           overrun_reg;
  logic           enh_access;
  logic           div_access;
  logic           enh_on;
  logic           presc_tick;
  logic           take;
  logic           rd_line_stat;
  logic           rd_modem_stat;
  logic           rd_data;
  logic [7:0]     line_status;
  logic [7:0]     modem_status;
  logic [7:0]     rdata_next;

  assign req = '{address: address, read: read, write: write, writedata: writedata};

  ust_sync #(.W(4)) u_modem_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     (modem_in_b),
    .q     (modem_s_b)
  );

  // Bus answers one cycle after the request appears
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      state_reg <= UST_IDLE;
    else
      case (state_reg)
        UST_IDLE: if (req.read || req.write) state_reg <= UST_ACK;
        UST_ACK:  state_reg <= UST_IDLE;
        default:  state_reg <= UST_IDLE;
      endcase
  end
  assign waitrequest = !(state_reg == UST_ACK);
  assign take        = (state_reg == UST_ACK);

  assign enh_access = (line_ctl_reg == `UST_LC_ENH_ACCESS);
  assign div_access = line_ctl_reg[`UST_LC_DIV_BIT] && !enh_access;
  assign enh_on     = enh_feat_reg[`UST_EF_ENH_BIT];
  assign loopback   = modem_ctl_reg[`UST_MC_LOOP_BIT];

  // line status hidden under enhanced access
  assign rd_line_stat  = take && req.read && !enh_access
                         && req.address == `UST_OFS_LINE_STAT;
  assign rd_modem_stat = take && req.read && !enh_access
                         && req.address == `UST_OFS_MODEM_STA;
  assign rd_data       = take && req.read && !div_access && !enh_access
                         && req.address == `UST_OFS_DATA;

  // Register writes
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      line_ctl_reg     <= `UST_LC_RESET;
      enh_feat_reg     <= 8'h00;
      modem_ctl_reg    <= `UST_MC_RESET;
      factory_test_reg <= `UST_FT_RESET;
      div_low_reg      <= 8'h01;
      div_high_reg     <= 8'h00;
    end
    else if (take && req.write)
    begin
      if (req.address == `UST_OFS_LINE_CTL)
        line_ctl_reg <= req.writedata;
      else if (enh_access && req.address == `UST_OFS_ENH_FEAT)
        enh_feat_reg <= req.writedata;
      else if (enh_access)
        enh_feat_reg <= enh_feat_reg;
      else if (div_access && req.address == `UST_OFS_DATA)
        div_low_reg <= req.writedata;
      else if (div_access && req.address == `UST_OFS_DIV_HIGH)
        div_high_reg <= req.writedata;
      else if (req.address == `UST_OFS_MODEM_CTL)
      begin
        if (enh_on)
          modem_ctl_reg <= req.writedata;
        else
          modem_ctl_reg <= (req.writedata & ~`UST_MC_EXT_MASK)
                           | (modem_ctl_reg & `UST_MC_EXT_MASK);
      end
      else if (req.address == `UST_OFS_LINE_STAT)
        // write at shared offset hits factory test
        // reserved bits dropped if software slips
        factory_test_reg <= req.writedata & `UST_FT_USED_MASK;
    end
  end

  ust_prescaler #(.DIV(`UST_PRESC_DIV)) u_presc (
    .clock  (clock),
    .rst_b  (rst_b),
    .divide (modem_ctl_reg[`UST_MC_PRESC_BIT] && enh_on),
    .tick   (presc_tick)
  );

  // Baud counter reloads from divisor; zero divisor holds
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      baud_cnt_reg <= 16'h0000;
    else if (presc_tick)
      baud_cnt_reg <= (baud_cnt_reg <= 16'h0001) ? {div_high_reg, div_low_reg}
                                                  : baud_cnt_reg - 16'h0001;
  end
  assign baud_tick = presc_tick && baud_cnt_reg == 16'h0001;

  // overrun sticky, set wins over read clear
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      overrun_reg <= 1'b0;
    else if (rx_byte_arrived && rx_full)
      overrun_reg <= 1'b1;
    else if (rd_line_stat)
      overrun_reg <= 1'b0;
  end

  // head byte flags, cleared by pop
  assign line_status = {rx_any_err, tx_empty && !tx_shift_busy, !tx_full,
                        rx_head.rx_valid && rx_head.rx_break,
                        rx_head.rx_valid && rx_head.rx_frame_err,
                        rx_head.rx_valid && rx_head.rx_parity_err,
                        overrun_reg, rx_head.rx_valid};

  assign status_now = loopback ? {modem_ctl_reg[3], modem_ctl_reg[2],
                                  modem_ctl_reg[0], modem_ctl_reg[1]}
                               : {~modem_s_b.cd, ~modem_s_b.ri,
                                  ~modem_s_b.dsr, ~modem_s_b.cts};

  // change latches; RI edge only on trailing edge of ring
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      status_prev_reg <= 4'h0;
      delta_reg       <= 4'h0;
    end
    else
    begin
      status_prev_reg <= status_now;
      delta_reg[0] <= (status_now[0] ^ status_prev_reg[0]) || (delta_reg[0] && !rd_modem_stat);
      delta_reg[1] <= (status_now[1] ^ status_prev_reg[1]) || (delta_reg[1] && !rd_modem_stat);
      delta_reg[2] <= (!status_now[2] && status_prev_reg[2])
                      || (delta_reg[2] && !rd_modem_stat);
      delta_reg[3] <= (status_now[3] ^ status_prev_reg[3]) || (delta_reg[3] && !rd_modem_stat);
    end
  end
  assign modem_status = {status_now, delta_reg};
  // modem interrupt request, enable held outside
  assign modem_irq    = |delta_reg;

  // Read mux
  always_comb
  begin
    rdata_next = 8'h00;
    if (enh_access && req.address == `UST_OFS_ENH_FEAT)
      rdata_next = enh_feat_reg;
    else if (req.address == `UST_OFS_LINE_CTL)
      rdata_next = line_ctl_reg;
    else if (enh_access)
      rdata_next = 8'h00;
    else if (div_access && req.address == `UST_OFS_DATA)
      rdata_next = factory_test_reg[4] ? baud_cnt_reg[7:0] : div_low_reg;
    else if (div_access && req.address == `UST_OFS_DIV_HIGH)
      rdata_next = factory_test_reg[4] ? baud_cnt_reg[15:8] : div_high_reg;
    else if (req.address == `UST_OFS_DATA)
      rdata_next = factory_test_reg[0] ? tx_test_data : rx_head.rx_data;
    else if (req.address == `UST_OFS_MODEM_CTL)
      rdata_next = modem_ctl_reg;
    else if (req.address == `UST_OFS_LINE_STAT)
      // read at shared offset is line status
      rdata_next = line_status;
    else if (req.address == `UST_OFS_MODEM_STA)
      rdata_next = modem_status;
  end
  assign readdata = rdata_next;

  // Data port strobes
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      tx_push      <= 1'b0;
      tx_data      <= 8'h00;
      rx_test_push <= 1'b0;
      rx_pop       <= 1'b0;
      tx_test_pop  <= 1'b0;
    end
    else
    begin
      tx_push      <= take && req.write && !div_access && !enh_access
                      && req.address == `UST_OFS_DATA && !factory_test_reg[1];
      rx_test_push <= take && req.write && !div_access && !enh_access
                      && req.address == `UST_OFS_DATA && factory_test_reg[1];
      rx_pop       <= rd_data && !factory_test_reg[0];
      tx_test_pop  <= rd_data && factory_test_reg[0];
      if (take && req.write)
        tx_data <= req.writedata;
    end
  end

  // no shifting in transmit test mode
  assign tx_inhibit    = factory_test_reg[0];
  assign tx_bad_parity = factory_test_reg[2];
  assign tx_bad_stop   = factory_test_reg[3];
  assign dtr_b         = ~modem_ctl_reg[0] | loopback;
  assign rts_b         = ~modem_ctl_reg[1] | loopback;

  a_bus_answer: assert property (@(posedge clock) disable iff (!rst_b)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  a_overrun_clear: assert property (@(posedge clock) disable iff (!rst_b)
    rd_line_stat && !(rx_byte_arrived && rx_full) |=> !line_status[1])
    else $error("overrun not cleared");
  a_overrun_set: assert property (@(posedge clock) disable iff (!rst_b)
    rx_byte_arrived && rx_full |=> line_status[1])
    else $error("overrun not set");
  a_delta_read: assert property (@(posedge clock) disable iff (!rst_b)
    rd_modem_stat && status_now == status_prev_reg |=> delta_reg[1:0] == 2'b00)
    else $error("delta not cleared");
  a_ri_rise: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(status_prev_reg[2]) |=> !delta_reg[2] || $past(delta_reg[2]))
    else $error("ri wrong edge");
  a_loop_mirror: assert property (@(posedge clock) disable iff (!rst_b)
    loopback |-> modem_status[4] == modem_ctl_reg[1])
    else $error("loopback cts mirror");
  a_ext_gate: assert property (@(posedge clock) disable iff (!rst_b)
    !enh_on |=> $stable(modem_ctl_reg[7]))
    else $error("extended bit changed");
  a_temt_tx: assert property (@(posedge clock) disable iff (!rst_b)
    tx_shift_busy |-> !line_status[6])
    else $error("transmit empty wrong");
  a_test_push: assert property (@(posedge clock) disable iff (!rst_b)
    rx_test_push |-> !tx_push)
    else $error("test push collides");
  c_line_read: cover property (@(posedge clock) rd_line_stat);
  c_modem_delta: cover property (@(posedge clock) |delta_reg);
  c_loopback: cover property (@(posedge clock) loopback && rd_modem_stat);
endmodule : ust_top

//--- sim/ust_far_model.sv
/*
 Far-side model of the UART status block: a one-entry receive store and a
 small transmit store with a shifter-busy level.
 Assumes the bench loads receive bytes and sets the shifter state.
*/
`timescale 1ns/1ps
module ust_far_model #(
  parameter int TX_DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Bench control
  input  wire logic             rx_load,
  input  wire ust_pkg::ust_rx_t rx_load_val,
  input  wire logic             tx_busy,
  // Receive storage
  input  wire logic             rx_pop,
  input  wire logic             rx_test_push,
  output      ust_pkg::ust_rx_t rx_head,
  output      logic             rx_full,
  output      logic             rx_any_err,
  // Transmit storage
  input  wire logic             tx_push,
  input  wire logic [7:0]       tx_data,
  input  wire logic             tx_test_pop,
  output      logic             tx_full,
  output      logic             tx_empty,
  output      logic             tx_shift_busy,
  output      logic [7:0]       tx_test_data
);
  import ust_pkg::*;
  int tx_count_reg;
  // head flags
  // Emptied head shows inverted data so stale bytes never match
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rx_head <= '0;
    else if (rx_load)
      rx_head <= rx_load_val;
    else if (rx_test_push)
      rx_head <= '{1'b1, tx_data, 1'b0, 1'b0, 1'b0};
    else if (rx_pop)
      rx_head <= '{1'b0, ~rx_head.rx_data, 1'b0, 1'b0, 1'b0};
  end
  assign rx_full    = rx_head.rx_valid;
  assign rx_any_err = rx_head.rx_valid
                      & (rx_head.rx_parity_err | rx_head.rx_frame_err | rx_head.rx_break);
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      tx_count_reg <= 0;
    else if (tx_push && tx_count_reg < TX_DEPTH)
      tx_count_reg <= tx_count_reg + 1;
    else if (tx_test_pop && tx_count_reg > 0)
      tx_count_reg <= tx_count_reg - 1;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      tx_test_data <= 8'h00;
    else if (tx_push)
      tx_test_data <= tx_data;
  end
  assign tx_full       = (tx_count_reg == TX_DEPTH);
  assign tx_empty      = (tx_count_reg == 0);
  assign tx_shift_busy = tx_busy;
endmodule : ust_far_model

//--- sim/tb_top.sv
/*
 Self-checking bench of the UART status and test block over Avalon-MM.
 Assumes ust_far_model on the far side and the pins driven from here.
*/
`timescale 1ns/1ps
module tb_top;
  import ust_pkg::*;
  logic clock, rst_b, read, write, waitrequest, dtr_b, rts_b, modem_irq;
  logic [2:0] address;
  logic [7:0] writedata, readdata, tx_data, tx_test_data, q;
  ust_modem_t modem_in_b;
  ust_rx_t    rx_head, rx_load_val;
  logic rx_full, rx_any_err, rx_byte_arrived, rx_pop, rx_test_push, rx_load, tx_busy;
  logic tx_full, tx_empty, tx_shift_busy, tx_push, tx_test_pop;
  logic tx_inhibit, tx_bad_parity, tx_bad_stop, baud_tick, loopback;
  int mismatches, checked, cycles, p0, p1;
  int n_rx_pop, n_tx_push, n_tx_test_pop, n_rx_test_push;

  ust_top u_ust_top (.clock, .rst_b, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .modem_in_b, .dtr_b, .rts_b, .modem_irq, .rx_head, .rx_full,
    .rx_any_err, .rx_byte_arrived, .rx_pop, .rx_test_push, .tx_full, .tx_empty,
    .tx_shift_busy, .tx_test_data, .tx_push, .tx_data, .tx_test_pop, .tx_inhibit,
    .tx_bad_parity, .tx_bad_stop, .baud_tick, .loopback);
  ust_far_model u_ust_far_model (.clock, .rst_b, .rx_load, .rx_load_val, .tx_busy,
    .rx_pop, .rx_test_push, .rx_head, .rx_full, .rx_any_err, .tx_push, .tx_data,
    .tx_test_pop, .tx_full, .tx_empty, .tx_shift_busy, .tx_test_data);

  always #10 clock = ~clock;

  always @(posedge clock)
  begin
    n_rx_pop       += (rx_pop === 1'b1);
    n_tx_push      += (tx_push === 1'b1);
    n_tx_test_pop  += (tx_test_pop === 1'b1);
    n_rx_test_push += (rx_test_push === 1'b1);
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Counts: checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low or 50 cycles pass
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    if (n >= 50)
      mismatches++;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    bus(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask : rdc

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  task automatic rxload(input logic [7:0] d, input logic [2:0] f);
    @(posedge clock);
    rx_load     <= 1'b1;
    rx_load_val <= '{1'b1, d, f[2], f[1], f[0]};
    @(posedge clock);
    rx_load     <= 1'b0;
  endtask : rxload

  // Counts inside the task so no edge is shared with another process
  task automatic ticks(input int e);
    int n;
    n = 0;
    repeat (40)
    begin
      @(posedge clock);
      n += (baud_tick === 1'b1);
    end
    chk(8'(n), 8'(e));
  endtask : ticks

  initial
  begin
    clock = 0; rst_b = 0; address = 0; read = 0; write = 0; writedata = 0;
    modem_in_b = 4'hF; rx_load = 0; rx_load_val = '0; rx_byte_arrived = 0; tx_busy = 0;
    mismatches = 0; checked = 0; cycles = 0;
    n_rx_pop = 0; n_tx_push = 0; n_tx_test_pop = 0; n_rx_test_push = 0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rdc(3'h5, 8'h60);
    rdc(3'h6, 8'h00);
    rdc(3'h7, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 3; i++)
    begin
      rxload(8'h41 + 8'(i), 3'b100 >> i);
      rdc(3'h5, 8'hE1 | (8'h04 << i));
      p0 = n_rx_pop;
      rdc(3'h0, 8'h41 + 8'(i));
      idle(3);
      chk(8'(n_rx_pop - p0), 8'h01);
      rdc(3'h5, 8'h60);
    end
    $display("test receive flags done");
    rxload(8'h55, 3'b000);
    @(posedge clock);
    rx_byte_arrived <= 1'b1;
    @(posedge clock);
    rx_byte_arrived <= 1'b0;
    rdc(3'h5, 8'h63);
    rdc(3'h5, 8'h61);
    rdc(3'h0, 8'h55);
    $display("test overrun done");
    tx_busy <= 1'b1;
    rdc(3'h5, 8'h20);
    tx_busy <= 1'b0;
    wr(3'h5, 8'h01);
    idle(2);
    chk(8'(tx_inhibit), 8'h01);
    p0 = n_tx_push;
    wr(3'h0, 8'h3C);
    wr(3'h0, 8'h3D);
    idle(3);
    chk(8'(n_tx_push - p0), 8'h02);
    rdc(3'h5, 8'h00);
    p1 = n_tx_test_pop;
    rdc(3'h0, 8'h3D);
    bus(1'b0, 3'h0, 8'h00);
    idle(3);
    chk(8'(n_tx_test_pop - p1), 8'h02);
    rdc(3'h5, 8'h60);
    wr(3'h5, 8'h0C);
    idle(2);
    chk({6'h00, tx_bad_parity, tx_bad_stop}, 8'h03);
    chk(8'(tx_inhibit), 8'h00);
    wr(3'h5, 8'h02);
    p0 = n_rx_test_push;
    wr(3'h0, 8'h77);
    idle(3);
    chk(8'(n_rx_test_push - p0), 8'h01);
    rdc(3'h0, 8'h77);
    wr(3'h5, 8'h00);
    idle(2);
    chk({6'h00, tx_bad_parity, tx_bad_stop}, 8'h00);
    $display("test factory modes done");
    modem_in_b <= 4'b0111;
    idle(6);
    chk(8'(modem_irq), 8'h01);
    rdc(3'h6, 8'h11);
    rdc(3'h6, 8'h10);
    modem_in_b <= 4'b0101;
    idle(6);
    rdc(3'h6, 8'h50);
    modem_in_b <= 4'b0111;
    idle(6);
    rdc(3'h6, 8'h14);
    modem_in_b <= 4'b1010;
    idle(6);
    rdc(3'h6, 8'hAB);
    modem_in_b <= 4'hF;
    idle(6);
    rdc(3'h6, 8'h0A);
    $display("test modem status done");
    wr(3'h4, 8'h03);
    idle(2);
    chk({6'h00, dtr_b, rts_b}, 8'h00);
    wr(3'h4, 8'h15);
    idle(6);
    chk({6'h00, dtr_b, loopback}, 8'h03);
    rdc(3'h6, 8'h60, 8'hF0);
    wr(3'h4, 8'h00);
    idle(6);
    chk(8'(loopback), 8'h00);
    rdc(3'h6, 8'h00, 8'hF0);
    $display("test loopback done");
    wr(3'h4, 8'h80);
    ticks(40);
    wr(3'h3, 8'hBF);
    rdc(3'h5, 8'h00);
    wr(3'h2, 8'h10);
    rdc(3'h2, 8'h10);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h80);
    ticks(10);
    wr(3'h4, 8'h00);
    ticks(40);
    wr(3'h3, 8'h80);
    rdc(3'h0, 8'h01);
    wr(3'h1, 8'h12);
    rdc(3'h1, 8'h12);
    // Counter reloaded 0x1201 just after the write; a few cycles later it reads 0x11xx
    wr(3'h5, 8'h10);
    rdc(3'h1, 8'h11);
    wr(3'h5, 8'h00);
    rdc(3'h1, 8'h12);
    wr(3'h3, 8'h00);
    $display("test prescaler and divisor done");
    complete_run();
  end
endmodule : tb_top
